/* mme_pkg.sv */
// constants and types for the monitor mode entry block
package mme_pkg;
  // ************
  // register map
  // ************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RX = 4'h8;
  localparam logic [3:0] ADDR_TX = 4'hc;
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_WDIS_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************
  // timing counts
  // ************
  localparam logic [4:0] SAMPLE_EDGES = 5'h18;
  localparam logic [1:0] BUS_DIV_LAST = 2'h3;
  localparam logic [3:0] INT_DIV_LAST = 4'hf;
  localparam logic [9:0] BAUD_LAST = 10'h3ff;
  localparam logic [9:0] BAUD_HALF = 10'h1ff;
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [3:0] SEC_LAST = 4'h7;
  // ************
  // vectors and patterns
  // ************
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [7:0] PAGE_USER = 8'hff;
  localparam logic [7:0] PAGE_MON = 8'hfe;
  localparam logic [7:0] VEC_RESET_LO = 8'hfe;
  localparam logic [7:0] VEC_SWI_LO = 8'hfc;
  localparam logic [9:0] BREAK_FRAME = 10'h000;
  typedef enum logic [1:0] {MODE_SAMPLE, MODE_USER, MODE_NORMAL, MODE_FORCED} mme_mode_t;
  typedef enum logic [1:0] {PH_SECURITY, PH_BREAK, PH_COMMAND} mme_phase_t;
endpackage : mme_pkg

/* mme_top.sv */
// monitor mode entry, clock and watchdog steering, vectors and monitor link
//
// Summary of operation
// - two monitor entries: test voltage with mode pins, or erased reset vectors.
// - serial select must stay low 24 reference edges after reset for monitor.
// - normal monitor bus clock is reference clock divided by four.
// - normal monitor leaves reset on external clock, not internal oscillator.
// - in normal monitor, test voltage on interrupt pin forces external clock; else control bit.
// - normal monitor disables watchdog under test voltage; else config bit rules.
// - below test voltage, erased reset vectors raise internal reset into monitor.
// - forced monitor starts on internal clock until software selects external.
// - watchdog stays disabled through forced monitor mode.
// - forced monitor persists over every reset except power-on, or one with test voltage or serial select high.
// - monitor vectors on page fe, user vectors on page ff.
// - while reset is low, nothing runs and bus clock stays stopped.
// - monitor traffic uses one open-drain data pin, pulled up outside.
// - monitor mode leaves all other pins their normal function.
// - link uses mark/space non-return-to-zero framing.
// - forced monitor bit rate is reference clock divided by 1024.
// - eight security bytes echoed; unlock only if all match; relock on reset.
// - after security bytes, send break of ten zero bits.
`timescale 1ns/1ps
module mme_top import mme_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_pulse,
  // register bus
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic ext_reference_clock,
  input wire logic irq_at_test_high_voltage,
  input wire logic rst_at_test_high_voltage,
  input wire logic mode_select_low_pin,
  input wire logic mode_select_high_pin,
  input wire logic serial_select_pin,
  input wire logic monitor_data_pin_in,
  output logic monitor_data_pin_out,
  output logic monitor_data_pin_oe,
  // reset vector fetch and vector selection
  input wire logic rvec_data_valid,
  input wire logic rvec_low_byte,
  input wire logic [7:0] rvec_data,
  input wire logic vector_is_swi,
  input wire logic vector_low_byte,
  input wire logic [63:0] security_bytes,
  // system controls
  output logic [15:0] vector_addr,
  output logic bus_clk_en,
  output logic clk_src_external,
  output logic watchdog_enable,
  output logic internal_reset
);
  // ************
  // pin synchronisers
  // ************
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pin_raw, sync1_reg, sync2_reg;
  logic ext_prev_reg, ext_tick;
  logic irq_tst, rst_tst, msel_lo, msel_hi, ssel, data_in;
  assign pin_raw = {ext_reference_clock, irq_at_test_high_voltage, rst_at_test_high_voltage,
                    mode_select_low_pin, mode_select_high_pin, serial_select_pin,
                    monitor_data_pin_in};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate
  assign {irq_tst, rst_tst, msel_lo, msel_hi, ssel, data_in} = sync2_reg[5:0];
  assign ext_tick = sync2_reg[6] & ~ext_prev_reg;

  function automatic logic is_monitor(input mme_mode_t m);
    return (m == MODE_NORMAL) || (m == MODE_FORCED);
  endfunction : is_monitor

  // ************
  // state
  // ************
  mme_mode_t mode_reg, mode_next;
  mme_phase_t phase_reg, phase_next;
  logic [4:0] samp_reg, samp_next;
  logic ssel_ok_reg, ssel_ok_next, rst_tst_reg, rst_tst_next;
  logic forced_reg, forced_next;
  logic [1:0] bdiv_reg, bdiv_next;
  logic [3:0] idiv_reg, idiv_next;
  logic bus_en_reg, bus_en_next, clk_ext_reg, clk_ext_next, wdog_reg, wdog_next;
  logic [15:0] vec_reg, vec_next;
  logic erased_hi_reg, erased_hi_next, int_rst_reg, int_rst_next;
  logic [9:0] rxc_reg, rxc_next, txc_reg, txc_next, txs_reg, txs_next;
  logic [3:0] rxb_reg, rxb_next, txb_reg, txb_next, sec_reg, sec_next;
  logic [7:0] rxs_reg, rxs_next, rxd_reg, rxd_next;
  logic rx_busy_reg, rx_busy_next, rxv_reg, rxv_next, tx_busy_reg, tx_busy_next;
  logic match_reg, match_next, unlock_reg, unlock_next, oe_reg, oe_next;
  logic [1:0] ctrl_reg, ctrl_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [3:0] awa_reg, awa_next;
  logic [7:0] wd_reg, wd_next;
  logic wlane_reg, wlane_next;
  logic awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next, arr_reg, arr_next;
  logic rv_reg, rv_next;
  logic [1:0] br_reg, br_next, rr_reg, rr_next;
  logic [31:0] rd_reg, rd_next;
  logic byte_done, tx_load;
  logic [9:0] tx_frame;

  always_comb begin
    mode_next = mode_reg;
    phase_next = phase_reg;
    samp_next = samp_reg;
    ssel_ok_next = ssel_ok_reg;
    rst_tst_next = rst_tst_reg;
    forced_next = forced_reg;
    bdiv_next = bdiv_reg;
    idiv_next = idiv_reg + 4'h1;
    erased_hi_next = erased_hi_reg;
    int_rst_next = 1'b0;
    rxc_next = rxc_reg;
    rxb_next = rxb_reg;
    rxs_next = rxs_reg;
    rxd_next = rxd_reg;
    rx_busy_next = rx_busy_reg;
    rxv_next = rxv_reg;
    txc_next = txc_reg;
    txb_next = txb_reg;
    txs_next = txs_reg;
    tx_busy_next = tx_busy_reg;
    sec_next = sec_reg;
    match_next = match_reg;
    unlock_next = unlock_reg;
    ctrl_next = ctrl_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    wlane_next = wlane_reg;
    bv_next = bv_reg;
    br_next = br_reg;
    rv_next = rv_reg;
    rr_next = rr_reg;
    rd_next = rd_reg;
    byte_done = 1'b0;
    tx_load = 1'b0;
    tx_frame = BREAK_FRAME;
    // mode decision at the close of the window
    if (mode_reg == MODE_SAMPLE && ext_tick) begin
      samp_next = samp_reg + 5'h1;
      ssel_ok_next = ssel_ok_reg & ~ssel;
      if (samp_next == SAMPLE_EDGES) begin
        rst_tst_next = rst_tst;
        if (ssel_ok_next && irq_tst && msel_hi && !msel_lo)
          mode_next = MODE_NORMAL;
        else if (ssel_ok_next && forced_reg && !rst_tst && !irq_tst)
          mode_next = MODE_FORCED;
        else
          mode_next = MODE_USER;
      end
    end
    // erased reset vectors in user mode restart into forced monitor
    if (mode_reg == MODE_USER && rvec_data_valid) begin
      if (!rvec_low_byte) begin
        erased_hi_next = (rvec_data == ERASED);
      end else if (erased_hi_reg && rvec_data == ERASED && !rst_tst_reg) begin
        int_rst_next = 1'b1;
        forced_next = 1'b1;
      end
    end
    // bus clock: reference over four, or the internal divider
    if (clk_ext_reg) begin
      if (ext_tick)
        bdiv_next = bdiv_reg + 2'h1;
    end else if (idiv_reg == INT_DIV_LAST) begin
      bdiv_next = BUS_DIV_LAST;
    end
    bus_en_next = (clk_ext_reg ? ext_tick : (idiv_reg == INT_DIV_LAST))
                  && (bdiv_reg == BUS_DIV_LAST || !clk_ext_reg);
    // test voltage in sample or normal mode forces external; otherwise the control bit selects
    clk_ext_next = ((mode_reg == MODE_SAMPLE || mode_reg == MODE_NORMAL) && irq_tst)
                   || ctrl_reg[CTRL_EXT_BIT];
    unique case (mode_reg)
      MODE_SAMPLE: wdog_next = 1'b0;
      MODE_USER: wdog_next = ~ctrl_reg[CTRL_WDIS_BIT];
      MODE_NORMAL: wdog_next = ~irq_tst & ~ctrl_reg[CTRL_WDIS_BIT];
      MODE_FORCED: wdog_next = 1'b0;
    endcase
    vec_next = {is_monitor(mode_reg) ? PAGE_MON : PAGE_USER,
                (vector_is_swi ? VEC_SWI_LO : VEC_RESET_LO) | {7'h0, vector_low_byte}};
    // receiver, bit time is reference over 1024, sampled mid-bit
    if (is_monitor(mode_reg)) begin
      if (!rx_busy_reg && !tx_busy_reg && !data_in) begin
        rx_busy_next = 1'b1;
        rxc_next = BAUD_HALF;
        rxb_next = 4'h0;
      end else if (rx_busy_reg && ext_tick) begin
        rxc_next = rxc_reg - 10'h1;
        if (rxc_reg == 10'h0) begin
          rxc_next = BAUD_LAST;
          rxb_next = rxb_reg + 4'h1;
          if (rxb_reg == 4'h0 && data_in)
            rx_busy_next = 1'b0;
          else if (rxb_reg == FRAME_LAST) begin
            rx_busy_next = 1'b0;
            byte_done = data_in;
          end else if (rxb_reg != 4'h0)
            rxs_next = {data_in, rxs_reg[7:1]};
        end
      end
    end
    // security bytes echoed, then break, then command traffic
    unique case (phase_reg)
      PH_SECURITY: if (byte_done) begin
        match_next = match_reg & (rxs_reg == security_bytes[{sec_reg[2:0], 3'h0} +: 8]);
        sec_next = sec_reg + 4'h1;
        tx_load = 1'b1;
        tx_frame = {1'b1, rxs_reg, 1'b0};
        if (sec_reg == SEC_LAST)
          phase_next = PH_BREAK;
      end
      PH_BREAK: if (!tx_busy_reg) begin
        tx_load = 1'b1;
        tx_frame = BREAK_FRAME;
        unlock_next = match_reg;
        phase_next = PH_COMMAND;
      end
      PH_COMMAND: if (byte_done) begin
        rxd_next = rxs_reg;
      end
      default: phase_next = PH_SECURITY;
    endcase
    // register bus, write side
    if (s_axi_awvalid && awr_reg) begin
      aw_have_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_reg) begin
      w_have_next = 1'b1;
      wd_next = s_axi_wdata[7:0];
      wlane_next = s_axi_wstrb[0];
    end
    if (bv_reg && s_axi_bready)
      bv_next = 1'b0;
    if (aw_have_reg && w_have_reg && !bv_reg) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bv_next = 1'b1;
      br_next = RESP_OKAY;
      unique case (awa_reg)
        ADDR_CTRL: if (wlane_reg) ctrl_next = wd_reg[1:0];
        ADDR_TX: if (wlane_reg && phase_reg == PH_COMMAND && !tx_busy_reg && !tx_load) begin
          tx_load = 1'b1;
          tx_frame = {1'b1, wd_reg, 1'b0};
        end
        ADDR_STATUS, ADDR_RX: ;
        default: br_next = RESP_SLVERR;
      endcase
    end
    // register bus, read side; reading received data frees it
    if (rv_reg && s_axi_rready)
      rv_next = 1'b0;
    if (s_axi_arvalid && arr_reg) begin
      rv_next = 1'b1;
      rr_next = RESP_OKAY;
      rd_next = 32'h0;
      unique case (s_axi_araddr)
        ADDR_CTRL: rd_next = {30'h0, ctrl_reg};
        ADDR_STATUS: rd_next = {22'h0, tx_busy_reg, rxv_reg, sec_reg, unlock_reg,
                                forced_reg, 2'(mode_reg)};
        ADDR_RX: begin
          rd_next = {24'h0, rxd_reg};
          rxv_next = 1'b0;
        end
        ADDR_TX: ;
        default: rr_next = RESP_SLVERR;
      endcase
    end
    if (byte_done && phase_reg == PH_COMMAND)
      rxv_next = 1'b1;
    awr_next = !aw_have_next && !bv_next;
    wr_next = !w_have_next && !bv_next;
    arr_next = !rv_next;
    // transmitter drives the pin low only, the pull-up gives the ones
    if (tx_load) begin
      tx_busy_next = 1'b1;
      txs_next = tx_frame;
      txc_next = BAUD_LAST;
      txb_next = 4'h0;
    end else if (tx_busy_reg && ext_tick) begin
      txc_next = txc_reg - 10'h1;
      if (txc_reg == 10'h0) begin
        txc_next = BAUD_LAST;
        txs_next = {1'b1, txs_reg[9:1]};
        txb_next = txb_reg + 4'h1;
        if (txb_reg == FRAME_LAST)
          tx_busy_next = 1'b0;
      end
    end
    oe_next = tx_busy_next && !txs_next[0];
  end

  // ************
  // registers
  // ************
  // survives ordinary resets, only power-on clears it
  always_ff @(posedge aclk) begin
    if (por_pulse)
      forced_reg <= 1'b0;
    else
      forced_reg <= forced_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= MODE_SAMPLE;
      phase_reg <= PH_SECURITY;
      samp_reg <= 5'h0;
      ssel_ok_reg <= 1'b1;
      rst_tst_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
      bdiv_reg <= 2'h0;
      idiv_reg <= 4'h0;
      bus_en_reg <= 1'b0;
      clk_ext_reg <= 1'b0;
      wdog_reg <= 1'b0;
      vec_reg <= 16'h0;
      erased_hi_reg <= 1'b0;
      int_rst_reg <= 1'b0;
      {rxc_reg, rxb_reg, rxs_reg, rxd_reg, rx_busy_reg, rxv_reg} <= 32'h0;
      {txc_reg, txb_reg, txs_reg, tx_busy_reg} <= 25'h0;
      sec_reg <= 4'h0;
      match_reg <= 1'b1;
      unlock_reg <= 1'b0;
      oe_reg <= 1'b0;
      ctrl_reg <= CTRL_RESET;
      {aw_have_reg, w_have_reg, awa_reg, wd_reg, wlane_reg} <= 15'h0;
      {awr_reg, wr_reg, bv_reg, arr_reg, rv_reg} <= 5'h0;
      {br_reg, rr_reg, rd_reg} <= 36'h0;
    end else begin
      mode_reg <= mode_next;
      phase_reg <= phase_next;
      samp_reg <= samp_next;
      ssel_ok_reg <= ssel_ok_next;
      rst_tst_reg <= rst_tst_next;
      ext_prev_reg <= sync2_reg[6];
      bdiv_reg <= bdiv_next;
      idiv_reg <= idiv_next;
      bus_en_reg <= bus_en_next;
      clk_ext_reg <= clk_ext_next;
      wdog_reg <= wdog_next;
      vec_reg <= vec_next;
      erased_hi_reg <= erased_hi_next;
      int_rst_reg <= int_rst_next;
      {rxc_reg, rxb_reg, rxs_reg, rxd_reg, rx_busy_reg, rxv_reg} <=
        {rxc_next, rxb_next, rxs_next, rxd_next, rx_busy_next, rxv_next};
      {txc_reg, txb_reg, txs_reg, tx_busy_reg} <= {txc_next, txb_next, txs_next, tx_busy_next};
      sec_reg <= sec_next;
      match_reg <= match_next;
      unlock_reg <= unlock_next;
      oe_reg <= oe_next;
      ctrl_reg <= ctrl_next;
      {aw_have_reg, w_have_reg, awa_reg, wd_reg, wlane_reg} <=
        {aw_have_next, w_have_next, awa_next, wd_next, wlane_next};
      {awr_reg, wr_reg, bv_reg, arr_reg, rv_reg} <= {awr_next, wr_next, bv_next, arr_next, rv_next};
      {br_reg, rr_reg, rd_reg} <= {br_next, rr_next, rd_next};
    end
  end

  assign s_axi_awready = awr_reg;
  assign s_axi_wready = wr_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rresp = rr_reg;
  assign s_axi_rdata = rd_reg;
  assign monitor_data_pin_out = 1'b0;
  assign monitor_data_pin_oe = oe_reg; // only this pin is claimed
  assign vector_addr = vec_reg;
  assign bus_clk_en = bus_en_reg;
  assign clk_src_external = clk_ext_reg;
  assign watchdog_enable = wdog_reg;
  assign internal_reset = int_rst_reg;

  // ************
  // checks
  // ************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_break_start;
    phase_reg == PH_BREAK && !tx_busy_reg;
  endsequence
  a_bus_clock_stopped: assert property (disable iff (1'b0) !aresetn |=> !bus_clk_en)
    else $error("bus clock ran during reset");
  a_vector_page_mon: assert property (is_monitor(mode_reg) |=> vector_addr[15:8] == PAGE_MON)
    else $error("monitor vector not on monitor page");
  a_vector_page_user: assert property (mode_reg == MODE_USER |=> vector_addr[15:8] == PAGE_USER)
    else $error("user vector not on user page");
  a_wdog_forced_off: assert property (mode_reg == MODE_FORCED |=> !watchdog_enable)
    else $error("watchdog on in forced monitor");
  a_wdog_normal_tst: assert property (mode_reg == MODE_NORMAL && irq_tst |=> !watchdog_enable)
    else $error("watchdog on under test voltage");
  a_clk_ext_tst: assert property (mode_reg == MODE_NORMAL && irq_tst |=> clk_src_external)
    else $error("external clock not selected");
  a_mode_held: assert property (mode_reg != MODE_SAMPLE |=> $stable(mode_reg))
    else $error("mode changed after latching");
  a_erased_restart: assert property (internal_reset |-> forced_reg && !rst_tst_reg)
    else $error("internal reset without forced entry");
  a_break_zeros: assert property (s_break_start |=> monitor_data_pin_oe [*8])
    else $error("break not driven low");
endmodule : mme_top

/* mme_host.sv */
// host side model of the single-wire monitor link
`timescale 1ns/1ps
module mme_host #(
  parameter int BIT_CYC = 2048
) (
  // clock
  input wire logic aclk,
  // open-drain line, pulled up outside
  input wire logic line,
  output logic pull_low
);
  // ************
  // frame tasks
  // ************
  initial pull_low = 1'b0;
  // start 0, data lsb first; returns as the stop bit begins so the echo is not missed
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 9; i++) begin
      pull_low <= ~f[i];
      repeat (BIT_CYC) @(posedge aclk);
    end
    pull_low <= 1'b0;
  endtask : send_byte
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (line && n < 4 * BIT_CYC) begin
      @(posedge aclk);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge aclk);
      b[i] = line;
    end
    repeat (BIT_CYC) @(posedge aclk);
    ok = (n < 4 * BIT_CYC) && line;
  endtask : recv_byte
endmodule : mme_host

/* monitor_mode_entry_tb_top.sv */
// self-checking bench for the monitor mode entry block
`timescale 1ns/1ps
module monitor_mode_entry_tb_top import mme_pkg::*;;
  // ************
  // signals
  // ************
  logic aclk, aresetn, por_pulse;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ext_reference_clock, irq_at_test_high_voltage, rst_at_test_high_voltage;
  logic mode_select_low_pin, mode_select_high_pin, serial_select_pin;
  wire logic monitor_data_pin_in;
  logic monitor_data_pin_out, monitor_data_pin_oe, host_low;
  logic rvec_data_valid, rvec_low_byte, vector_is_swi, vector_low_byte;
  logic [7:0] rvec_data, sent, echo;
  logic [63:0] security_bytes;
  logic [15:0] vector_addr;
  logic bus_clk_en, clk_src_external, watchdog_enable, internal_reset, ok;
  logic [31:0] d;
  int error_cnt, comparisons, cyc, r;
  // pull-up wins unless someone pulls low
  assign monitor_data_pin_in = ~(monitor_data_pin_oe | host_low);
  mme_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .por_pulse(por_pulse),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ext_reference_clock(ext_reference_clock),
    .irq_at_test_high_voltage(irq_at_test_high_voltage),
    .rst_at_test_high_voltage(rst_at_test_high_voltage),
    .mode_select_low_pin(mode_select_low_pin), .mode_select_high_pin(mode_select_high_pin),
    .serial_select_pin(serial_select_pin), .monitor_data_pin_in(monitor_data_pin_in),
    .monitor_data_pin_out(monitor_data_pin_out), .monitor_data_pin_oe(monitor_data_pin_oe),
    .rvec_data_valid(rvec_data_valid), .rvec_low_byte(rvec_low_byte), .rvec_data(rvec_data),
    .vector_is_swi(vector_is_swi), .vector_low_byte(vector_low_byte),
    .security_bytes(security_bytes), .vector_addr(vector_addr), .bus_clk_en(bus_clk_en),
    .clk_src_external(clk_src_external), .watchdog_enable(watchdog_enable),
    .internal_reset(internal_reset)
  );
  mme_host #(.BIT_CYC(2048)) i_host (.aclk(aclk), .line(monitor_data_pin_in), .pull_low(host_low));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // one reference tick every two cycles
  always @(posedge aclk) ext_reference_clock <= ~ext_reference_clock;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 100000) begin
      error_cnt++;
      close_out();
    end
  end
  // ************
  // tasks
  // ************
  task automatic close_out();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic chk_rate(input int e);
    int c;
    c = 0;
    repeat (400) begin
      @(posedge aclk);
      if (bus_clk_en === 1'b1) c++;
    end
    comparisons++;
    if (c < e - 1 || c > e + 1) begin
      error_cnt++;
      $display("unexpected bus_clk_en count exp %0d got %0d", e, c);
    end
  endtask : chk_rate
  // only word-aligned offsets are mapped, the rest answer slave error
  function automatic logic [1:0] exp_resp(input logic [3:0] a);
    return (a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
  endfunction : exp_resp
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    int n;
    logic done;
    logic [1:0] b;
    n = 0;
    done = 1'b0;
    b = 2'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && n < 200) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        b = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
    chk("write_done", 1, done);
    chk("bresp", {30'h0, exp_resp(a)}, {30'h0, b});
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    int n;
    logic done;
    logic [1:0] b;
    n = 0;
    done = 1'b0;
    b = 2'h0;
    v = 32'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && n < 200) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) begin
        v = s_axi_rdata;
        b = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
    chk("read_done", 1, done);
    chk("rresp", {30'h0, exp_resp(a)}, {30'h0, b});
  endtask : rd
  task automatic restart(input logic irq, input logic rt, input logic hi, input logic lo,
                         input logic por, input logic ss);
    int c;
    c = 0;
    irq_at_test_high_voltage <= irq;
    rst_at_test_high_voltage <= rt;
    mode_select_high_pin <= hi;
    mode_select_low_pin <= lo;
    serial_select_pin <= ss;
    aresetn <= 1'b0;
    por_pulse <= por;
    @(posedge aclk);
    por_pulse <= 1'b0;
    repeat (7) begin
      @(posedge aclk);
      if (bus_clk_en !== 1'b0) c++;
    end
    chk("bus_clk_en_in_reset", 0, c);
    aresetn <= 1'b1;
    repeat (100) @(posedge aclk);
  endtask : restart
  task automatic chk_state(input logic [1:0] m, input logic x, input logic w);
    rd(ADDR_STATUS, d);
    chk("mode", {30'h0, m}, {30'h0, d[1:0]});
    chk("clk_src_external", {31'h0, x}, {31'h0, clk_src_external});
    chk("watchdog_enable", {31'h0, w}, {31'h0, watchdog_enable});
  endtask : chk_state
  function automatic logic [15:0] exp_vec(input logic mon, input logic software_interrupt, input logic low);
    return {mon ? 8'hfe : 8'hff, (software_interrupt ? 8'hfc : 8'hfe) | {7'h0, low}};
  endfunction : exp_vec
  task automatic chk_vec(input logic mon);
    for (int k = 0; k < 4; k++) begin
      vector_is_swi <= k[1];
      vector_low_byte <= k[0];
      repeat (3) @(posedge aclk);
      chk("vector_addr", {16'h0, exp_vec(mon, k[1], k[0])}, {16'h0, vector_addr});
    end
  endtask : chk_vec
  task automatic fetch(input logic [7:0] lo, input logic [7:0] hi, input int e);
    int c;
    c = 0;
    // high byte is fetched first, as the core reads the vector
    rvec_data_valid <= 1'b1;
    rvec_low_byte <= 1'b0;
    rvec_data <= hi;
    @(posedge aclk);
    rvec_low_byte <= 1'b1;
    rvec_data <= lo;
    @(posedge aclk);
    rvec_data_valid <= 1'b0;
    repeat (12) begin
      @(posedge aclk);
      if (internal_reset === 1'b1) c++;
    end
    chk("internal_reset_pulses", e, c);
  endtask : fetch
  // ************
  // sequence
  // ************
  initial begin
    {aresetn, por_pulse, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, rvec_data_valid, rvec_low_byte} = '0;
    {vector_is_swi, vector_low_byte, ext_reference_clock, serial_select_pin} = '0;
    {irq_at_test_high_voltage, rst_at_test_high_voltage} = '0;
    {mode_select_low_pin, mode_select_high_pin} = '0;
    s_axi_awaddr = 4'h0;
    s_axi_araddr = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    rvec_data = 8'h00;
    r = $urandom(32'h0fe2);
    security_bytes = {$urandom, $urandom};
    restart(1'b0, 1'b0, 1'($urandom), 1'($urandom), 1'b1, 1'b0);
    chk_state(MODE_USER, 1'b0, 1'b1);
    chk_rate(25);
    chk_vec(1'b0);
    chk("monitor_data_pin_out", 0, monitor_data_pin_out);
    fetch(8'($urandom_range(0, 254)), 8'($urandom), 0);
    r = $urandom_range(0, 1);
    wr(ADDR_CTRL, {30'h0, r[0], 1'b1});
    rd(ADDR_CTRL, d);
    chk("ctrl_readback", {30'h0, r[0], 1'b1}, d);
    chk_rate(50);
    wr(ADDR_STATUS, 32'hffff_ffff);
    chk_state(MODE_USER, 1'b1, ~r[0]);
    r = $urandom_range(1, 3);
    wr(4'(r), 32'hffff_ffff);
    rd(4'(r), d);
    chk("unmapped_rdata", 0, d);
    fetch(ERASED, ERASED, 1);
    restart(1'b0, 1'b0, 1'($urandom), 1'($urandom), 1'b0, 1'b0);
    chk_state(MODE_FORCED, 1'b0, 1'b0);
    chk_vec(1'b1);
    wr(ADDR_CTRL, 32'h1);
    chk_state(MODE_FORCED, 1'b1, 1'b0);
    restart(1'b0, 1'b0, 1'($urandom), 1'($urandom), 1'b0, 1'b0);
    chk_state(MODE_FORCED, 1'b0, 1'b0);
    restart(1'b0, 1'b1, 1'($urandom), 1'($urandom), 1'b1, 1'b0);
    fetch(ERASED, ERASED, 0);
    restart(1'b0, 1'b1, 1'($urandom), 1'($urandom), 1'b0, 1'b0);
    rd(ADDR_STATUS, d);
    chk("mode_reset_pin_test", MODE_USER, {30'h0, d[1:0]});
    restart(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    chk_state(MODE_USER, 1'b0, 1'b1);
    restart(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    chk_state(MODE_NORMAL, 1'b1, 1'b0);
    chk_rate(50);
    chk_vec(1'b1);
    sent = security_bytes[7:0];
    i_host.send_byte(sent);
    i_host.recv_byte(echo, ok);
    chk("echo", {24'h0, sent}, {24'h0, echo});
    chk("echo_stop", 1, ok);
    rd(ADDR_STATUS, d);
    chk("security_count", 1, {28'h0, d[7:4]});
    irq_at_test_high_voltage <= 1'b0;
    wr(ADDR_CTRL, 32'h0);
    chk_state(MODE_NORMAL, 1'b0, 1'b1);
    wr(ADDR_CTRL, 32'h3);
    chk_state(MODE_NORMAL, 1'b1, 1'b0);
    close_out();
  end
endmodule : monitor_mode_entry_tb_top
